//--- core/axb_slot_ctrl.sv
// Behaviour
// [R01] All slot logic runs from the core clock
// [R02] Synchronous only for integer ratio up to 16; the ratio is not checked, any differing ratio gets the synchronous converter
// [R03] Ratios compared only when async flag clear
// [R04] Slave slot converter when async or ratio differs
// [R05] Master slot converter when async or ratio differs
// [R06] Flag clear, ratio differs: synchronous converter
// [R07] Flag set: asynchronous FIFO converter
// [R08] Unused range: base all ones, high zero
// [R09] Ranges 4k, power of two, aligned
// [R10] Used ranges never overlap
// [R11] Range legality not checked here
// [R12] Addresses are fixed 32 bits
// [R13] Address forwarded unchanged; range selects slot
// [R14] Master slot decodable through several ranges
// [R15] One endpoint region outstanding per slot thread
// [R16] Reordering masters drive distinct thread IDs
// [R17] Full ID is thread bits OR base
// [R18] Base ID low thread bits zero
// [R19] Responses routed back by base ID decode
// [R20] Zero thread bits: single ID, no sampling
// [R21] Cascaded IDs prefixed, responses returned upstream
// [R22] Master ID width at least one
// [R23] Unmatched address answered with decode error
//
// Added by the designer: the placing of the registers and register access over Wishbone.
module axb_slot_ctrl #(
   parameter int NS  = 2,
   parameter int NM  = 2,
   parameter int NR  = 2,
   parameter int IDW = 8,
   parameter int TW  = 4,
   parameter int CW  = 4
) (
   input  wire  logic                   mclk,     // [R01]
   input  wire  logic                   rstn,
   // Wishbone classic slave
   input  wire  logic                   wb_cyc_i,
   input  wire  logic                   wb_stb_i,
   input  wire  logic                   wb_we_i,
   input  wire  logic [7:0]             wb_adr_i,
   input  wire  logic [3:0]             wb_sel_i,
   input  wire  logic [31:0]            wb_dat_i,
   output logic                         wb_ack_o,
   output logic [31:0]                  wb_dat_o,
   // Request decode
   input  wire  logic                   req_valid,
   input  wire  logic [$clog2(NS)-1:0]  req_si,
   input  wire  logic [axb_pkg::ADDR_W-1:0] req_addr,
   input  wire  logic [TW-1:0]          req_thread,
   output logic                         fwd_valid,
   output logic [$clog2(NM)-1:0]        fwd_mi,
   output logic [axb_pkg::ADDR_W-1:0]   fwd_addr,
   output logic [IDW-1:0]               fwd_id,
   output logic [$clog2(NS)-1:0]        fwd_si,
   output logic                         req_decerr,
   output logic                         req_stall,
   // Completion of a forwarded transaction
   input  wire  logic                   cpl_valid,
   input  wire  logic [$clog2(NS)-1:0]  cpl_si,
   // Response routing
   input  wire  logic                   rsp_valid,
   input  wire  logic [IDW-1:0]         rsp_id,
   output logic                         rsp_route_valid,
   output logic [$clog2(NS)-1:0]        rsp_si,
   output logic                         rsp_miss,
   // Converter selection per slot
   output logic [NS-1:0][1:0]           conv_si,
   output logic [NM-1:0][1:0]           conv_mi,
   // Slot clock sampled for period measurement
   input  wire  logic                   link_clk
);

   // Derived widths
   localparam int SW = $clog2(NS);
   localparam int MW = $clog2(NM);
   localparam int NK = NM * NR;
   localparam int KW = $clog2(NK);
   localparam int TBITS_WX = axb_pkg::TBITS_W;

   typedef struct packed {
      // Configuration
      logic [15:0]                 core_ratio;
      logic [NS-1:0]               si_async;
      logic [NM-1:0]               mi_async;
      logic [NS-1:0][15:0]         si_ratio;
      logic [NS-1:0][TBITS_WX-1:0] si_tbits;
      logic [NS-1:0][IDW-1:0]      si_bid;
      logic [NM-1:0][15:0]         mi_ratio;
      logic [NK-1:0][31:0]         rbase;
      logic [NK-1:0][31:0]         rhigh;
      // Outstanding count and region per slave slot
      logic [NS-1:0][CW-1:0]       ocnt;
      logic [NS-1:0][KW-1:0]       oreg;
      // Registered outputs
      logic                        wb_ack;
      logic [31:0]                 wb_dat;
      logic                        fwd_valid;
      logic [MW-1:0]               fwd_mi;
      logic [31:0]                 fwd_addr;
      logic [IDW-1:0]              fwd_id;
      logic [SW-1:0]               fwd_si;
      logic                        decerr;
      logic                        stall;
      logic                        rsp_v;
      logic [SW-1:0]               rsp_si;
      logic                        rsp_miss;
      logic [NS-1:0][1:0]          conv_si;
      logic [NM-1:0][1:0]          conv_mi;
      // Slot clock sampling
      logic                        s1;
      logic                        s2;
      logic                        s3;
      logic                        lvl;
      logic [15:0]                 pcnt;
      logic [15:0]                 period;
   } axb_state_s;

   axb_state_s q;
   axb_state_s d;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] conv_sel(input logic asy, input logic [15:0] r, input logic [15:0] c);
      // Ratio only matters for a synchronous slot
      if (asy)
         return 2'(axb_pkg::CONV_ASYNC);                 // [R07]
      else if (r != c)
         return 2'(axb_pkg::CONV_SYNC);                  // [R06] [R03]
      else
         return 2'(axb_pkg::CONV_NONE);
   endfunction

   function automatic logic [IDW-1:0] tmask(input logic [TBITS_WX-1:0] tb);
      logic [IDW-1:0] m;
      m = '0;
      for (int b = 0; b < IDW; b++)
         m[b] = (b < int'(tb));
      return m;
   endfunction

   function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
         if (s[b]) r[8*b +: 8] = n[8*b +: 8];
      return r;
   endfunction

   function automatic axb_state_s rst_state();
      axb_state_s r;
      r = '0;
      r.core_ratio = axb_pkg::RATIO_RST;
      for (int i = 0; i < NS; i++) begin
         r.si_ratio[i] = axb_pkg::RATIO_RST;
         // Distinct base ids keep slots separable out of reset
         r.si_bid[i]   = IDW'(i);
      end
      for (int i = 0; i < NM; i++)
         r.mi_ratio[i] = axb_pkg::RATIO_RST;
      for (int k = 0; k < NK; k++) begin
         r.rbase[k] = axb_pkg::BASE_RST;                 // [R08]
         r.rhigh[k] = axb_pkg::HIGH_RST;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0]    rd;
      logic [31:0]    wv;
      logic           hit;
      logic [KW-1:0]  hk;
      logic           busy;
      logic [NS-1:0]  inc;
      logic [NS-1:0]  dec;
      logic           rhit;
      logic [SW-1:0]  rsi;
      rd   = '0;
      wv   = '0;
      hit  = 1'b0;
      hk   = '0;
      busy = 1'b0;
      inc  = '0;
      dec  = '0;
      rhit = 1'b0;
      rsi  = '0;
      // Pulses default low, all other state holds
      d    = q;
      d.wb_ack    = 1'b0;
      d.fwd_valid = 1'b0;
      d.decerr    = 1'b0;
      d.stall     = 1'b0;
      d.rsp_v     = 1'b0;
      d.rsp_miss  = 1'b0;

      // Register access; unmapped reads zero, writes dropped
      if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
         d.wb_ack = 1'b1;
         if (wb_adr_i == axb_pkg::REG_CORE_RATIO)
            rd = {16'h0000, q.core_ratio};
         if (wb_adr_i == axb_pkg::REG_ASYNC)
            rd = 32'(q.si_async) | (32'(q.mi_async) << axb_pkg::MI_ASY_LSB);
         if (wb_adr_i == axb_pkg::REG_CONV)
            rd = 32'(q.conv_si) | (32'(q.conv_mi) << axb_pkg::MI_CNV_LSB);
         if (wb_adr_i == axb_pkg::REG_PERIOD)
            rd = {16'h0000, q.period};
         for (int i = 0; i < NS; i++)
            if (wb_adr_i == 8'(axb_pkg::REG_SI_BASE + axb_pkg::REG_STRIDE * i))
               rd = (32'(q.si_bid[i]) << axb_pkg::BID_LSB) |
                    (32'(q.si_tbits[i]) << axb_pkg::TBITS_LSB) | 32'(q.si_ratio[i]);
         for (int i = 0; i < NM; i++)
            if (wb_adr_i == 8'(axb_pkg::REG_MI_BASE + axb_pkg::REG_STRIDE * i))
               rd = 32'(q.mi_ratio[i]);
         for (int k = 0; k < NK; k++) begin
            if (wb_adr_i == 8'(axb_pkg::REG_RNG_BASE + axb_pkg::RNG_STRIDE * k))
               rd = q.rbase[k];
            if (wb_adr_i == 8'(axb_pkg::REG_RNG_BASE + axb_pkg::RNG_STRIDE * k + axb_pkg::REG_STRIDE))
               rd = q.rhigh[k];
         end
         d.wb_dat = wb_we_i ? 32'h00000000 : rd;
         if (wb_we_i) begin
            wv = bmerge(rd, wb_dat_i, wb_sel_i);
            // Range legality is the configuring party's duty
            if (wb_adr_i == axb_pkg::REG_CORE_RATIO)      // [R11]
               d.core_ratio = wv[axb_pkg::RATIO_LSB +: axb_pkg::RATIO_W];
            if (wb_adr_i == axb_pkg::REG_ASYNC) begin
               d.si_async = wv[NS-1:0];
               d.mi_async = wv[axb_pkg::MI_ASY_LSB +: NM];
            end
            for (int i = 0; i < NS; i++)
               if (wb_adr_i == 8'(axb_pkg::REG_SI_BASE + axb_pkg::REG_STRIDE * i)) begin
                  d.si_ratio[i] = wv[axb_pkg::RATIO_LSB +: axb_pkg::RATIO_W];
                  d.si_tbits[i] = wv[axb_pkg::TBITS_LSB +: axb_pkg::TBITS_W];
                  d.si_bid[i]   = wv[axb_pkg::BID_LSB +: IDW];
               end
            for (int i = 0; i < NM; i++)
               if (wb_adr_i == 8'(axb_pkg::REG_MI_BASE + axb_pkg::REG_STRIDE * i))
                  d.mi_ratio[i] = wv[axb_pkg::RATIO_LSB +: axb_pkg::RATIO_W];
            for (int k = 0; k < NK; k++) begin
               if (wb_adr_i == 8'(axb_pkg::REG_RNG_BASE + axb_pkg::RNG_STRIDE * k))
                  d.rbase[k] = wv;
               if (wb_adr_i == 8'(axb_pkg::REG_RNG_BASE + axb_pkg::RNG_STRIDE * k + axb_pkg::REG_STRIDE))
                  d.rhigh[k] = wv;
            end
         end
      end

      // Converter choice, re-evaluated every cycle
      for (int i = 0; i < NS; i++)
         d.conv_si[i] = conv_sel(q.si_async[i], q.si_ratio[i], q.core_ratio);   // [R04] [R02]
      for (int i = 0; i < NM; i++)
         d.conv_mi[i] = conv_sel(q.mi_async[i], q.mi_ratio[i], q.core_ratio);   // [R05] [R02]

      // Address decode; lowest range index wins, unused never matches
      for (int k = NK - 1; k >= 0; k--)
         if (req_addr >= q.rbase[k] && req_addr <= q.rhigh[k]) begin     // [R08] [R14]
            hit = 1'b1;
            hk  = KW'(k);
         end
      // A full counter stalls too, so the count never wraps
      // Per-slot tracking is stricter than per thread, trading concurrency for size
      busy = (q.ocnt[req_si] != '0 && q.oreg[req_si] != hk) || (&q.ocnt[req_si]);  // [R15]
      // Completion and forward in one cycle both apply
      for (int i = 0; i < NS; i++)
         dec[i] = cpl_valid && (cpl_si == SW'(i)) && (q.ocnt[i] != '0);
      if (req_valid) begin
         if (!hit)
            d.decerr = 1'b1;                                              // [R23]
         else if (busy)
            d.stall = 1'b1;
         else begin
            d.fwd_valid = 1'b1;
            d.fwd_mi    = MW'(int'(hk) / NR);                             // [R13]
            d.fwd_addr  = req_addr;                                       // [R12] [R13]
            d.fwd_si    = req_si;
            // Thread bits above the slot width are not sampled
            d.fwd_id    = q.si_bid[req_si] |
                          (IDW'(req_thread) & tmask(q.si_tbits[req_si])); // [R17] [R20] [R21]
            d.oreg[req_si] = hk;
            inc[req_si] = 1'b1;
         end
      end
      for (int i = 0; i < NS; i++)
         d.ocnt[i] = q.ocnt[i] + CW'(inc[i]) - CW'(dec[i]);

      // Response routing by base ID and thread width
      for (int i = NS - 1; i >= 0; i--)
         if ((rsp_id & ~tmask(q.si_tbits[i])) == q.si_bid[i]) begin       // [R19] [R18] [R21]
            rhit = 1'b1;
            rsi  = SW'(i);
         end
      if (rsp_valid) begin
         d.rsp_v    = rhit;
         d.rsp_si   = rsi;
         d.rsp_miss = !rhit;
      end

      // Slot clock: three stages, change taken when stages two and three agree
      d.s1 = link_clk;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3)
         d.lvl = q.s3;
      // Period count saturates when the slot clock stops; period keeps its last value
      if (q.pcnt != axb_pkg::CNT_MAX)
         d.pcnt = q.pcnt + 16'h0001;
      if (q.s2 == q.s3 && q.s3 && !q.lvl) begin
         d.period = q.pcnt;
         d.pcnt   = 16'h0001;
      end
   end

   // Synchronous reset restores the whole configuration
   always_ff @(posedge mclk) begin
      if (!rstn)
         q <= rst_state();
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus side
   assign wb_ack_o        = q.wb_ack;
   assign wb_dat_o        = q.wb_dat;

   // Request side
   assign fwd_valid       = q.fwd_valid;
   assign fwd_mi          = q.fwd_mi;
   assign fwd_addr        = q.fwd_addr;
   assign fwd_id          = q.fwd_id;
   assign fwd_si          = q.fwd_si;
   assign req_decerr      = q.decerr;
   assign req_stall       = q.stall;

   // Response side
   assign rsp_route_valid = q.rsp_v;
   assign rsp_si          = q.rsp_si;
   assign rsp_miss        = q.rsp_miss;

   // Converter codes
   assign conv_si         = q.conv_si;
   assign conv_mi         = q.conv_mi;

endmodule

//--- core/axb_pkg.sv
package axb_pkg;

   // Converter placed on a slot
   typedef enum logic [1:0] {
      CONV_NONE,
      CONV_SYNC,
      CONV_ASYNC
   } axb_conv_e;

   // Fixed transaction address width
   localparam int ADDR_W = 32;

   // Register byte offsets (one 32-bit word each)
   localparam logic [7:0] REG_CORE_RATIO = 8'h00;
   localparam logic [7:0] REG_ASYNC      = 8'h04;
   localparam logic [7:0] REG_CONV       = 8'h08;
   localparam logic [7:0] REG_PERIOD     = 8'h0c;
   localparam logic [7:0] REG_SI_BASE    = 8'h10;
   localparam logic [7:0] REG_MI_BASE    = 8'h20;
   localparam logic [7:0] REG_RNG_BASE   = 8'h40;
   localparam logic [7:0] REG_STRIDE     = 8'h04;
   localparam logic [7:0] RNG_STRIDE     = 8'h08;

   // Field positions
   localparam int RATIO_LSB  = 0;
   localparam int RATIO_W    = 16;
   localparam int TBITS_LSB  = 16;
   localparam int TBITS_W    = 4;
   localparam int BID_LSB    = 24;
   localparam int MI_ASY_LSB = 16;
   localparam int MI_CNV_LSB = 16;

   // Reset values and period count limit
   localparam logic [15:0] RATIO_RST = 16'h0001;
   localparam logic [31:0] BASE_RST  = 32'hffffffff;
   localparam logic [31:0] HIGH_RST  = 32'h00000000;
   localparam logic [15:0] CNT_MAX   = 16'hffff;

endpackage

//--- verif/axb_slot_ctrl_chk.sv
module axb_slot_ctrl_chk #(
   parameter int NS = 2,
   parameter int NM = 2
) (
   input wire logic                  mclk,
   input wire logic                  rstn,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic                  wb_ack_o,
   input wire logic                  req_valid,
   input wire logic [$clog2(NS)-1:0] req_si,
   input wire logic [31:0]           req_addr,
   input wire logic                  fwd_valid,
   input wire logic [31:0]           fwd_addr,
   input wire logic [$clog2(NS)-1:0] fwd_si,
   input wire logic                  req_decerr,
   input wire logic                  req_stall,
   input wire logic                  rsp_valid,
   input wire logic                  rsp_route_valid,
   input wire logic                  rsp_miss,
   input wire logic [NS-1:0][1:0]    conv_si,
   input wire logic [NM-1:0][1:0]    conv_mi
);
   wire wr_done = wb_ack_o && wb_we_i;
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack late");
   property p_one;
      req_valid |=> $onehot({fwd_valid, req_decerr, req_stall});
   endproperty
   a_one: assert property (p_one) else $error("request answer not single");
   property p_addr;
      req_valid ##1 fwd_valid |-> fwd_addr == $past(req_addr);
   endproperty
   a_addr: assert property (p_addr) else $error("address altered");
   property p_src;
      req_valid ##1 fwd_valid |-> fwd_si == $past(req_si);
   endproperty
   a_src: assert property (p_src) else $error("source slot wrong");
   property p_cause;
      fwd_valid || req_decerr || req_stall |-> $past(req_valid);
   endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_rsp;
      rsp_valid |=> rsp_route_valid ^ rsp_miss;
   endproperty
   a_rsp: assert property (p_rsp) else $error("response not routed");
   property p_rcause;
      rsp_route_valid || rsp_miss |-> $past(rsp_valid);
   endproperty
   a_rcause: assert property (p_rcause) else $error("route without response");
   // Converter codes only follow register writes
   property p_conv;
      !$stable({conv_si, conv_mi}) |-> $past(wr_done) || $past(wr_done, 2);
   endproperty
   a_conv: assert property (p_conv) else $error("converter code moved");
   c_fwd: cover property (fwd_valid);
   c_dec: cover property (req_decerr);
   c_stall: cover property (req_stall);
   c_miss: cover property (rsp_miss);
endmodule

bind axb_slot_ctrl axb_slot_ctrl_chk #(.NS(NS), .NM(NM)) u_chk (
   .mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .req_valid, .req_si, .req_addr,
   .fwd_valid, .fwd_addr, .fwd_si, .req_decerr, .req_stall, .rsp_valid, .rsp_route_valid,
   .rsp_miss, .conv_si, .conv_mi
);

//--- verif/axb_far_model.sv
module axb_far_model (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       slow,
   input  wire logic       bad,
   input  wire logic       fwd_valid,
   input  wire logic [7:0] fwd_id,
   input  wire logic       fwd_si,
   output logic            cpl_valid,
   output logic            cpl_si,
   output logic            rsp_valid,
   output logic [7:0]      rsp_id,
   output logic            link_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [40:0] q[$];
   logic [31:0] cyc;
   // Slot clock 8:1 to core, free running, odd phase
   initial begin
      link_clk = 1'b0;
      #37;
      forever #100 link_clk = ~link_clk;
   end
   always @(posedge mclk) begin
      if (!rstn) begin
         q.delete();
         cyc <= 32'h0;
         cpl_valid <= 1'b0;
         cpl_si <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_id <= 8'h00;
      end else begin
         cyc <= cyc + 32'h1;
         if (fwd_valid)
            q.push_back({cyc + (slow ? 32'h1e : 32'h2), fwd_si, fwd_id});
         // Id echoed as received; bad only on command
         if (q.size() != 0 && q[0][40:9] <= cyc) begin
            cpl_valid <= 1'b1;
            cpl_si <= q[0][8];
            rsp_valid <= 1'b1;
            rsp_id <= q[0][7:0] | {bad, 7'h0};
            void'(q.pop_front());
         end else begin
            cpl_valid <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_id <= ~rsp_id;
         end
      end
   end
endmodule

//--- verif/test_axb_slot_ctrl.sv
module test_axb_slot_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [63:0] DEC = 64'h0000_0800_0000_0000;
   localparam logic [63:0] STL = 64'h0000_0400_0000_0000;
   logic            mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_valid, req_si;
   logic            fwd_valid, fwd_mi, fwd_si, req_decerr, req_stall, cpl_valid, cpl_si;
   logic            rsp_valid, rsp_route_valid, rsp_si, rsp_miss, link_clk, slow, bad;
   logic [7:0]      wb_adr_i, fwd_id, rsp_id;
   logic [3:0]      wb_sel_i, req_thread;
   logic [31:0]     wb_dat_i, wb_dat_o, req_addr, fwd_addr, r;
   logic [1:0][1:0] conv_si, conv_mi;
   logic [63:0]     qw[$], qr[$], qp[$];
   int              seed, num_errors, check_count;
   axb_slot_ctrl dut (.mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_ack_o, .wb_dat_o, .req_valid, .req_si, .req_addr, .req_thread, .fwd_valid, .fwd_mi,
      .fwd_addr, .fwd_id, .fwd_si, .req_decerr, .req_stall, .cpl_valid, .cpl_si, .rsp_valid,
      .rsp_id, .rsp_route_valid, .rsp_si, .rsp_miss, .conv_si, .conv_mi, .link_clk);
   axb_far_model far (.mclk, .rstn, .slow, .bad, .fwd_valid, .fwd_id, .fwd_si, .cpl_valid,
      .cpl_si, .rsp_valid, .rsp_id, .link_clk);
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic logic [63:0] fw(logic m, logic s, logic [7:0] i, logic [31:0] a);
      return {19'h0, 3'b100, m, s, i, a};
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'hf;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge mclk);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      qw.push_back(64'(e));
      bus(1'b0, a, 32'h0);
   endtask
   // Leaves the strobe up so requests can run back to back
   task automatic rq(input logic s, input logic [31:0] a, input logic [3:0] t, input logic [63:0] e);
      req_valid <= 1'b1;
      req_si <= s;
      req_addr <= a;
      req_thread <= t;
      qr.push_back(e);
      @(posedge mclk);
   endtask
   task automatic rq_off;
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
      @(posedge mclk);
   endtask
   task automatic quiet;
      repeat (3) @(posedge mclk);
      while (far.q.size() != 0)
         @(posedge mclk);
      repeat (3) @(posedge mclk);
   endtask
   ////////////////////////////////////////
   always @(posedge mclk) begin
      if (wb_ack_o && !wb_we_i)
         chk("rdata", qw.pop_front(), wb_dat_o);
      if (fwd_valid || req_decerr || req_stall)
         chk("request", qr.pop_front(), {19'h0, fwd_valid, req_decerr, req_stall,
            fwd_valid ? {fwd_mi, fwd_si, fwd_id, fwd_addr} : 42'h0});
      if (rsp_route_valid || rsp_miss)
         chk("response", qp.pop_front(), 64'({rsp_route_valid, rsp_miss, rsp_route_valid & rsp_si}));
      if (rsp_valid)
         qp.push_back(rsp_id[7:4] == 4'h1 ? 64'h4 : rsp_id == 8'h20 ? 64'h5 : 64'h2);
   end
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #500000;
      num_errors++;
      report_and_stop;
   end
   initial begin
      seed = 32'h24c40809;
      rstn = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, req_valid, req_si, slow, bad} = 7'h0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      req_addr = 32'h0;
      req_thread = 4'h0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rq(1'b0, 32'hffffffff, 4'h3, DEC);
      rq(1'b1, 32'h0, 4'h3, DEC);
      rq_off;
      for (int k = 0; k < 4; k++) begin
         rd(8'(8'h40 + 8 * k), 32'hffffffff);
         rd(8'(8'h44 + 8 * k), 32'h0);
      end
      rd(8'h00, 32'h1);
      rd(8'h14, 32'h01000001);
      rd(8'hfc, 32'h0);
      // Slot clock of 200 ns is eight core cycles
      rd(8'h0c, 32'h8);
      bus(1'b1, 8'h04, 32'h00020001);
      bus(1'b1, 8'h14, 32'h01000002);
      rd(8'h08, 32'h00080006);
      chk("conv", 64'h86, 64'({conv_mi, conv_si}));
      bus(1'b1, 8'h00, 32'h2);
      rd(8'h08, 32'h00090002);
      chk("conv", 64'h92, 64'({conv_mi, conv_si}));
      bus(1'b1, 8'h10, 32'h10040001);
      bus(1'b1, 8'h14, 32'h20000002);
      bus(1'b1, 8'h40, 32'h1000);
      bus(1'b1, 8'h44, 32'h1fff);
      bus(1'b1, 8'h50, 32'h8000);
      bus(1'b1, 8'h54, 32'h8fff);
      bus(1'b1, 8'h58, 32'h40000000);
      bus(1'b1, 8'h5c, 32'h4fffffff);
      rd(8'h10, 32'h10040001);
      rq(1'b0, 32'h2000, 4'h1, DEC);
      rq(1'b0, 32'h1abc, 4'h5, fw(1'b0, 1'b0, 8'h15, 32'h1abc));
      rq(1'b1, 32'h8ffc, 4'h9, fw(1'b1, 1'b1, 8'h20, 32'h8ffc));
      repeat (4) begin
         r = $random(seed);
         rq(1'b0, {20'h1, r[11:0]}, r[15:12], fw(1'b0, 1'b0, {4'h1, r[15:12]}, {20'h1, r[11:0]}));
      end
      rq_off;
      quiet;
      slow <= 1'b1;
      bad <= 1'b1;
      rq(1'b0, 32'h1000, 4'h0, fw(1'b0, 1'b0, 8'h10, 32'h1000));
      rq(1'b0, 32'h40000000, 4'h0, STL);
      rq(1'b0, 32'h1ff0, 4'h2, fw(1'b0, 1'b0, 8'h12, 32'h1ff0));
      rq(1'b1, 32'h40000000, 4'h2, fw(1'b1, 1'b1, 8'h20, 32'h40000000));
      rq_off;
      quiet;
      bad <= 1'b0;
      slow <= 1'b0;
      rq(1'b0, 32'h40000000, 4'h7, fw(1'b1, 1'b0, 8'h17, 32'h40000000));
      rq_off;
      quiet;
      chk("pending", 64'h0, 64'(qw.size() + qr.size() + qp.size()));
      report_and_stop;
   end
endmodule
